// *** rtl/smsp_core.sv ***
// byte serial port, master or slave, with wishbone register access
//
// What this block does
// - miso input as master, output as slave
// - eight-bit bytes, most significant bit first
// - mosi output as master, input as slave
// - clock driven as master, received as slave
// - master clock rate, polarity, phase from config
// - slave decodes clock with configured phase, any polarity
// - launch on one edge, sample on other
// - slave select low frames slave bytes
// - automatic select low during master transfer
// - select as input allows multimaster switching
// - continuous mode runs until buffer empty
// - single byte: write starts, flag, release
// - continuous select held until all empty
// - idle gap between bytes without continuous mode
// - transmit flag when shift register loads
// - master stops when buffer not refilled
// - receive flag when byte enters buffer
// - overflow flag, discard or overwrite new byte
// - port select gives pins to this port
// - receive read clears overflow and receive flags
// - full bit set on store, cleared by read
`timescale 1ns/1ps
module smsp_core (
  input  wire logic               sys_clk,   // core clock
  input  wire logic               rst_b,     // sync reset, low
  input  wire smsp_pkg::smsp_wbreq_t wbReq,  // wishbone request
  output logic [31:0]             wb_dat_o,  // read data
  output logic                    wb_ack_o,  // cycle answer
  input  wire logic               sclkIn,    // serial clock pin in
  input  wire logic               mosiIn,    // mosi pin in
  input  wire logic               misoIn,    // miso pin in
  input  wire logic               selIn_b,   // select pin in, low
  output smsp_pkg::smsp_pads_t    pads       // pin drives, enables
);
  import smsp_pkg::*;

  // two-stage synchronisers for every pin input
  logic [1:0] sclkSync_q;
  logic [1:0] mosiSync_q;
  logic [1:0] misoSync_q;
  logic [1:0] selSync_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sclkSync_q <= 2'h0;
      mosiSync_q <= 2'h0;
      misoSync_q <= 2'h0;
      selSync_q  <= 2'h3;
    end else begin
      sclkSync_q <= {sclkSync_q[0], sclkIn};
      mosiSync_q <= {mosiSync_q[0], mosiIn};
      misoSync_q <= {misoSync_q[0], misoIn};
      selSync_q  <= {selSync_q[0], selIn_b};
    end
  end

  // registers
  logic [7:0]  cfg1_q;
  logic [7:0]  cfg2_q;
  logic [7:0]  psel_q;
  logic [7:0]  txBuf_q;
  logic [7:0]  rxBuf_q;
  logic        txFull_q;
  logic        txEmpty_q;
  logic        rxNew_q;
  logic        rxFull_q;
  logic        ovf_q;
  // serial engine state
  smsp_state_t st_q;
  logic [8:0]  div_q;
  logic [EDGE_W-1:0] edge_q;
  logic [7:0]  txSh_q;
  logic [7:0]  rxSh_q;
  logic        sclk_q;
  logic        ssLow_q;
  logic        sclkPrev_q;
  logic        slvPrev_q;

  // bus decode; side effects happen on the edge that ack is seen
  logic        wbHit;
  logic        wbAct;
  logic        wrTx;
  logic        rdRx;
  assign wbHit = wbReq.cyc & wbReq.stb & !wb_ack_o;
  assign wbAct = wbReq.cyc & wbReq.stb & wb_ack_o;
  assign wrTx  = wbAct & wbReq.we & wbReq.sel[0]
               & (wbReq.adr == ADR_W'(IDX_TXBUF));
  assign rdRx  = wbAct & !wbReq.we & (wbReq.adr == ADR_W'(IDX_RXBUF));

  // mode decode
  logic        cpha;
  logic        cont;
  logic        spiSel;
  logic        masterEff;
  logic        slvAct;
  logic [8:0]  halfLast;
  assign cpha   = cfg2_q[CFG2_CPHA];
  assign cont   = cfg2_q[CFG2_CONT];
  assign spiSel = psel_q[PSEL_SPI];
  // select as input: a low select turns a master into a slave
  assign masterEff = cfg1_q[CFG1_MASTER]
                   & !(cfg1_q[CFG1_SSIN] & !selSync_q[1]);
  assign slvAct = !masterEff & spiSel & !selSync_q[1];
  // half period of 2^(rate+1) core cycles; rate 0 outruns the miso sync
  assign halfLast = (9'h002 << cfg1_q[RATE_W-1:0]) - 9'h001;

  // edge events: master from its divider, slave from the pin
  logic        tick;
  logic        edgeEv;
  logic        sampleNow;
  logic        shiftNow;
  logic        byteEnd;
  logic        din;
  logic [7:0]  rxNext;
  logic        loadNow;
  logic        ldTx;
  logic        txTaken;
  assign tick   = (st_q != ST_IDLE) & (div_q == halfLast);
  // a deselected slave sees no edges at all
  assign edgeEv = (masterEff & (st_q == ST_SHIFT) & tick)
                | (slvAct & (sclkSync_q[1] != sclkPrev_q));
  // sample on one edge of each pair, launch on the other
  assign sampleNow = edgeEv & (edge_q[0] == cpha);
  assign shiftNow  = edgeEv & (edge_q[0] != cpha)
                   & (edge_q != '0);
  assign byteEnd   = edgeEv & (edge_q == EDGE_LAST);
  assign din       = masterEff ? misoSync_q[1] : mosiSync_q[1];
  assign rxNext    = sampleNow ? {rxSh_q[6:0], din} : rxSh_q;
  // master loads from idle, or back to back when continuous
  assign loadNow = masterEff & spiSel & txFull_q
                 & ((st_q == ST_IDLE)
                    | ((st_q == ST_SHIFT) & byteEnd & cont));
  assign ldTx    = loadNow
                 | (slvAct & (!slvPrev_q | byteEnd));
  assign txTaken = ldTx & txFull_q;

  // wishbone answer: one wait state, ack for exactly one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbHit;
      if (wbHit) begin
        case (wbReq.adr)
          ADR_W'(IDX_RXBUF): wb_dat_o <= {24'h00_0000, rxBuf_q};
          ADR_W'(IDX_CFG1):  wb_dat_o <= {24'h00_0000, cfg1_q};
          ADR_W'(IDX_CFG2):  wb_dat_o <= {24'h00_0000, cfg2_q};
          ADR_W'(IDX_PSEL):  wb_dat_o <= {24'h00_0000, psel_q};
          ADR_W'(IDX_STAT):  wb_dat_o <= {26'h000_0000, ovf_q, rxNew_q,
                                         rxFull_q, 1'b0, txEmpty_q,
                                         txFull_q};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration and transmit buffer writes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cfg1_q  <= CFG1_RST;
      cfg2_q  <= CFG2_RST;
      psel_q  <= PSEL_RST;
      txBuf_q <= BUF_RST;
    end else if (wbAct & wbReq.we & wbReq.sel[0]) begin
      case (wbReq.adr)
        ADR_W'(IDX_CFG1):  cfg1_q  <= wbReq.dat[7:0];
        ADR_W'(IDX_CFG2):  cfg2_q  <= wbReq.dat[7:0];
        ADR_W'(IDX_PSEL):  psel_q  <= wbReq.dat[7:0];
        ADR_W'(IDX_TXBUF): txBuf_q <= wbReq.dat[7:0];
        default:           cfg1_q  <= cfg1_q;
      endcase
    end
  end

  // transmit flags; a hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      txFull_q  <= 1'b0;
      txEmpty_q <= 1'b0;
    end else begin
      if (txTaken) txFull_q <= 1'b0;
      if (wrTx) txFull_q <= 1'b1;
      if (wrTx) txEmpty_q <= 1'b0;
      if (txTaken) txEmpty_q <= 1'b1;
    end
  end

  // receive buffer and flags; a new byte wins over a read clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rxBuf_q  <= BUF_RST;
      rxNew_q  <= 1'b0;
      rxFull_q <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      if (rdRx) begin
        rxNew_q  <= 1'b0;
        ovf_q    <= 1'b0;
        rxFull_q <= 1'b0;
      end
      if (byteEnd) begin
        if (rxFull_q & !rdRx) begin
          ovf_q <= 1'b1;
          if (cfg1_q[CFG1_OVW]) begin
            rxBuf_q <= rxNext;
            rxNew_q <= 1'b1;
          end
        end else begin
          rxBuf_q  <= rxNext;
          rxNew_q  <= 1'b1;
          rxFull_q <= 1'b1;
        end
      end
    end
  end

  // shift registers and clock edge counter, shared by both modes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      txSh_q     <= BUF_RST;
      rxSh_q     <= BUF_RST;
      edge_q     <= '0;
      sclkPrev_q <= 1'b0;
      slvPrev_q  <= 1'b0;
    end else begin
      sclkPrev_q <= sclkSync_q[1];
      slvPrev_q  <= slvAct;
      // msb goes out first, captured bits enter at the bottom
      if (ldTx) txSh_q <= txBuf_q;
      else if (shiftNow) txSh_q <= {txSh_q[6:0], 1'b0};
      if (sampleNow) rxSh_q <= rxNext;
      // partial byte is dropped on release only if asked to
      if ((masterEff & (st_q == ST_IDLE))
          | (!masterEff & !slvAct & cfg2_q[CFG2_ENDC])) begin
        edge_q <= '0;
      end else if (edgeEv) begin
        edge_q <= edge_q + 4'h1;
      end
    end
  end

  // master sequencer: select, clock generation, gap, stop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q    <= ST_IDLE;
      div_q   <= 9'h000;
      sclk_q  <= 1'b0;
      ssLow_q <= 1'b0;
    end else if (!masterEff) begin
      st_q    <= ST_IDLE;
      div_q   <= 9'h000;
      sclk_q  <= cfg2_q[CFG2_CPOL];
      ssLow_q <= 1'b0;
    end else begin
      div_q <= (st_q == ST_IDLE || tick) ? 9'h000 : div_q + 9'h001;
      case (st_q)
        ST_IDLE: begin
          sclk_q <= cfg2_q[CFG2_CPOL];
          if (loadNow) begin
            st_q    <= ST_LEAD;
            ssLow_q <= cfg1_q[CFG1_AUTOSS];
          end
        end
        // half a period of select setup here; the first edge comes a further half period into shift
        ST_LEAD: begin
          if (tick) st_q <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (tick) sclk_q <= !sclk_q;
          if (byteEnd) begin
            if (cont & txFull_q) begin
              st_q <= ST_SHIFT;
            end else if (cont) begin
              st_q    <= ST_IDLE;
              ssLow_q <= 1'b0;
            end else begin
              st_q    <= ST_GAP;
              ssLow_q <= 1'b0;
            end
          end
        end
        ST_GAP: begin
          if (tick) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // pin drives, all registered; the other interface owns clock, mosi and miso
  // whenever the port select bit is clear; the select drive ignores that bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pads <= '{sclkOut: 1'b0, sclkOe: 1'b0, mosiOut: 1'b0,
                mosiOe: 1'b0, misoOut: 1'b0, misoOe: 1'b0,
                selOut_b: 1'b1, selOe: 1'b0};
    end else begin
      pads.sclkOut  <= sclk_q;
      pads.sclkOe   <= masterEff & spiSel;
      pads.mosiOut  <= txSh_q[7];
      pads.mosiOe   <= masterEff & spiSel;
      pads.misoOut  <= txSh_q[7];
      pads.misoOe   <= slvAct;
      pads.selOut_b <= !ssLow_q;
      pads.selOe    <= masterEff & cfg1_q[CFG1_AUTOSS]
                     & !cfg1_q[CFG1_SSIN];
    end
  end

  // checks
  miso_dir_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    pads.misoOe |-> !$past(masterEff) && !$past(selSync_q[1]))
    else $error("miso driven in master mode or deselected");

  mosi_dir_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    pads.mosiOe |-> $past(masterEff) && $past(spiSel))
    else $error("mosi driven outside master mode");

  sclk_dir_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    !masterEff ##1 !masterEff |-> !pads.sclkOe)
    else $error("clock driven in slave mode");

  sclk_idle_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == ST_LEAD |-> sclk_q == cfg2_q[CFG2_CPOL])
    else $error("clock not at idle polarity before first edge");

  tx_flag_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    txTaken && !wrTx |=> txEmpty_q && !txFull_q)
    else $error("transmit flag not raised on load");

  rx_store_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteEnd && !rxFull_q |=> rxNew_q && rxFull_q
      && rxBuf_q == $past(rxNext))
    else $error("received byte not stored");

  rx_ovf_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteEnd && rxFull_q && !rdRx && !cfg1_q[CFG1_OVW]
    |=> ovf_q && rxBuf_q == $past(rxBuf_q))
    else $error("overflow not flagged or byte not discarded");

  rd_clear_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdRx && !byteEnd |=> !ovf_q && !rxNew_q && !rxFull_q)
    else $error("receive read did not clear flags");

  auto_ss_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    masterEff && cfg1_q[CFG1_AUTOSS] && st_q == ST_LEAD
    ##1 st_q == ST_SHIFT |-> ssLow_q)
    else $error("select not low during transfer");

  stop_gap_a:
  assert property (@(posedge sys_clk) disable iff (!rst_b)
    masterEff && st_q == ST_SHIFT && byteEnd && !txFull_q
    |=> !ssLow_q && (st_q == (cont ? ST_IDLE : ST_GAP)))
    else $error("master did not stop or gap after byte");
endmodule : smsp_core

// *** rtl/smsp_pkg.sv ***
// register map, field layout and carrier types of the serial port
package smsp_pkg;
  // word index of each register; byte address is four times it
  localparam int unsigned ADR_W     = 10;
  localparam logic [7:0]  IDX_TXBUF = 8'h9A;
  localparam logic [7:0]  IDX_RXBUF = 8'h9B;
  localparam logic [7:0]  IDX_CFG1  = 8'hE8;
  localparam logic [7:0]  IDX_CFG2  = 8'hE9;
  localparam logic [7:0]  IDX_STAT  = 8'hEA;
  localparam logic [7:0]  IDX_PSEL  = 8'hAF;
  // first configuration register fields
  localparam int unsigned CFG1_MASTER = 7;
  localparam int unsigned CFG1_AUTOSS = 6;
  localparam int unsigned CFG1_OVW    = 5;
  localparam int unsigned CFG1_SSIN   = 4;
  localparam int unsigned RATE_W      = 3;
  // second configuration register fields
  localparam int unsigned CFG2_CONT = 7;
  localparam int unsigned CFG2_CPOL = 6;
  localparam int unsigned CFG2_CPHA = 5;
  localparam int unsigned CFG2_ENDC = 4;
  // status register fields
  localparam int unsigned ST_OVF    = 5;
  localparam int unsigned ST_RXNEW  = 4;
  localparam int unsigned ST_RXFULL = 3;
  localparam int unsigned ST_TXEMP  = 1;
  localparam int unsigned ST_TXFULL = 0;
  // peripheral select register field
  localparam int unsigned PSEL_SPI = 0;
  // reset values
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] PSEL_RST = 8'h01;
  localparam logic [7:0] BUF_RST  = 8'h00;
  // serial framing: eight bits, two clock edges per bit
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned EDGE_W = 4;
  localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hF;

  // master sequencer, gray coded along idle-lead-shift-gap
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LEAD  = 2'h1,
    ST_SHIFT = 2'h3,
    ST_GAP   = 2'h2
  } smsp_state_t;

  typedef struct packed {
    logic sclkOut;
    logic sclkOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
    logic selOut_b;
    logic selOe;
  } smsp_pads_t;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
    logic [3:0]       sel;
    logic             we;
    logic             stb;
    logic             cyc;
  } smsp_wbreq_t;
endpackage : smsp_pkg

// *** dv/smsp_slave_model.sv ***
// behavioural serial slave that answers the port when it runs as master
`timescale 1ns/1ps
module smsp_slave_model (
  input  wire logic       sclk,   // serial clock from master
  input  wire logic       mosi,   // data from master
  input  wire logic       sel_b,  // select, low active, pulled up
  input  wire logic       en,     // model attached to the lines
  input  wire logic [7:0] txByte, // byte sent back to master
  output logic            miso    // data to master
);
  logic [7:0] sh;
  logic [7:0] rxByte;
  int         bits;
  int         frames;

  initial begin
    sh = 8'h00;
    rxByte = 8'h00;
    bits = 0;
    frames = 0;
  end
  // frame start: first bit must stand before the first edge
  always @(negedge sel_b) begin
    sh = txByte;
    bits = 0;
  end
  // mode 0: sample on the rising edge
  always @(posedge sclk) if (!sel_b && en) begin
    rxByte = {rxByte[6:0], mosi};
    bits = bits + 1;
  end
  // launch on the falling edge, reload at each byte boundary
  always @(negedge sclk) if (!sel_b && en) begin
    sh = (bits % 8 == 0) ? txByte : {sh[6:0], 1'b0};
  end
  always @(posedge sel_b) frames = frames + 1;
  // a released line shows the inverse, never a stale level
  assign miso = (!sel_b && en) ? sh[7] : ~sh[7];
endmodule : smsp_slave_model

// *** dv/smsp_core_bench.sv ***
// self-checking bench for the serial port core
`timescale 1ns/1ps
module smsp_core_bench;
  import smsp_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  smsp_wbreq_t wbReq;
  logic [31:0] wbDat;
  logic        wbAck;
  smsp_pads_t  pads;
  logic        bSclk, bMosi, bSel_b, slvMiso, slvEn;
  logic        sclkW, mosiW, misoW, selW_b;
  logic [7:0]  slvTx, rd;
  int          err_total, compares, cycles;

  // pin levels from every driver's enable; select has a pull-up
  assign sclkW  = pads.sclkOe ? pads.sclkOut : bSclk;
  assign mosiW  = pads.mosiOe ? pads.mosiOut : bMosi;
  assign misoW  = pads.misoOe ? pads.misoOut : slvMiso;
  assign selW_b = pads.selOe ? pads.selOut_b : 1'b1;

  smsp_core u_smsp_core (.sys_clk(sys_clk), .rst_b(rst_b), .wbReq(wbReq),
    .wb_dat_o(wbDat), .wb_ack_o(wbAck), .sclkIn(sclkW), .mosiIn(mosiW),
    .misoIn(misoW), .selIn_b(bSel_b), .pads(pads));
  smsp_slave_model u_smsp_slave_model (.sclk(sclkW), .mosi(mosiW),
    .sel_b(selW_b), .en(slvEn), .txByte(slvTx), .miso(slvMiso));

  always #5 sys_clk = ~sys_clk;
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one classic cycle; idle edge first so strobes never retoggle
  task automatic wb(input logic [7:0] idx, input logic we,
                    input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{adr: {2'h0, idx}, dat: {24'h000000, wd}, sel: 4'hF,
               we: we, stb: 1'b1, cyc: 1'b1};
    @(posedge sys_clk);
    // only the hang guard ends this wait; one wait state is expected
    while (wbAck !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    rd = wbDat[7:0];
    wbReq <= '0;
    chk(8'(n), 8'h01, "bus latency");
  endtask : wb

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
    wb(idx, 1'b0, 8'h00);
    chk(rd, exp, what);
  endtask : rdChk

  // a frame ends when the model sees select return high
  task automatic byteRun(input logic [7:0] tx, input logic [7:0] slv);
    int f;
    int n;
    f = u_smsp_slave_model.frames;
    n = 0;
    slvTx = slv;
    wb(IDX_TXBUF, 1'b1, tx);
    while (u_smsp_slave_model.frames <= f && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    chk(8'(u_smsp_slave_model.frames - f), 8'h01, "one frame");
  endtask : byteRun

  task automatic testRegs;
    rdChk(IDX_CFG1, CFG1_RST, "cfg1 reset");
    rdChk(IDX_CFG2, CFG2_RST, "cfg2 reset");
    rdChk(IDX_PSEL, PSEL_RST, "psel reset");
    rdChk(IDX_STAT, 8'h00, "status reset");
    wb(IDX_STAT, 1'b1, 8'hFF);
    rdChk(IDX_STAT, 8'h00, "status read only");
    rdChk(8'h10, 8'h00, "unmapped");
    wb(IDX_CFG2, 1'b1, 8'h70);
    rdChk(IDX_CFG2, 8'h70, "cfg2 rw");
    wb(IDX_CFG2, 1'b1, 8'h00);
    chk({4'h0, pads.sclkOe, pads.mosiOe, pads.misoOe, pads.selOe}, 8'h00,
        "idle slave pins");
    // a master must leave clock and mosi to the other interface
    wb(IDX_CFG1, 1'b1, 8'h81);
    wb(IDX_PSEL, 1'b1, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({6'h00, pads.sclkOe, pads.mosiOe}, 8'h00, "pins handed over");
    wb(IDX_PSEL, 1'b1, 8'h01);
  endtask : testRegs

  task automatic testMaster;
    wb(IDX_CFG1, 1'b1, 8'hC1);
    slvTx = 8'h3C;
    wb(IDX_TXBUF, 1'b1, 8'hA5);
    repeat (8) @(posedge sys_clk);
    chk({4'h0, pads.sclkOe, pads.mosiOe, pads.misoOe, pads.selOut_b},
        8'h0C, "master pins");
    // rate 1: 80 ns clock, select back high some 70 cycles after load
    repeat (68) @(posedge sys_clk);
    chk(u_smsp_slave_model.rxByte, 8'hA5, "mosi byte");
    chk(8'(u_smsp_slave_model.bits), 8'h08, "bits");
    chk({6'h00, pads.sclkOut, pads.selOut_b}, 8'h01, "idle lines");
    rdChk(IDX_STAT, 8'h1A, "status after byte");
    rdChk(IDX_RXBUF, 8'h3C, "miso byte");
    rdChk(IDX_STAT, 8'h02, "status after read");
  endtask : testMaster

  task automatic testOverflow;
    byteRun(8'h01, 8'h11);
    byteRun(8'h02, 8'h22);
    rdChk(IDX_STAT, 8'h3A, "overflow");
    rdChk(IDX_RXBUF, 8'h11, "new byte dropped");
    wb(IDX_CFG1, 1'b1, 8'hE1);
    byteRun(8'h03, 8'h33);
    byteRun(8'h04, 8'h44);
    rdChk(IDX_RXBUF, 8'h44, "overwrite");
  endtask : testOverflow

  // one bus master only: refill in sequence, long before the byte ends
  task automatic testCont;
    int f;
    int n;
    f = u_smsp_slave_model.frames;
    n = 0;
    slvTx = 8'h5A;
    wb(IDX_CFG2, 1'b1, 8'h80);
    wb(IDX_TXBUF, 1'b1, 8'h81);
    rdChk(IDX_STAT, 8'h02, "flag on load");
    wb(IDX_TXBUF, 1'b1, 8'h82);
    while (u_smsp_slave_model.frames <= f && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    chk(8'(u_smsp_slave_model.frames - f), 8'h01, "one stream");
    chk(8'(u_smsp_slave_model.bits), 8'h10, "back to back");
    chk(u_smsp_slave_model.rxByte, 8'h82, "second byte");
    wb(IDX_CFG2, 1'b1, 8'h00);
    wb(IDX_RXBUF, 1'b0, 8'h00);
  endtask : testCont

  // the bench plays master at an 80 ns serial clock
  task automatic testSlave;
    logic [7:0] got;
    logic [7:0] tx;
    got = 8'h00;
    tx = 8'h69;
    slvEn = 1'b0;
    wb(IDX_CFG1, 1'b1, 8'h00);
    wb(IDX_TXBUF, 1'b1, 8'h96);
    bSel_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, pads.misoOe}, 8'h01, "slave drives miso");
    for (int i = 7; i >= 0; i--) begin
      bMosi <= tx[i];
      repeat (4) @(posedge sys_clk);
      bSclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      got = {got[6:0], pads.misoOut};
      bSclk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    chk(got, 8'h96, "slave miso byte");
    bSel_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, pads.misoOe}, 8'h00, "miso released");
    rdChk(IDX_RXBUF, 8'h69, "slave rx");
  endtask : testSlave

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    wbReq = '0;
    {bSclk, bMosi, bSel_b, slvEn} = 4'h3;
    slvTx = 8'h00;
    rd = 8'h00;
    err_total = 0;
    compares = 0;
    cycles = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    testRegs();
    testMaster();
    testOverflow();
    testCont();
    testSlave();
    print_verdict();
  end
endmodule : smsp_core_bench
